// ==== qbr_defines.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef QBR_DEFINES_SVH
`define QBR_DEFINES_SVH
`define QBR_OFF_CTRL      8'h00
`define QBR_OFF_FIBER     8'h04
`define QBR_OFF_DUPLEX    8'h08
`define QBR_OFF_STATUS    8'h0c
`define QBR_CTRL_BUSED    0
`define QBR_CTRL_SMART    1
`define QBR_CTRL_MLT3     2
`define QBR_CTRL_SCRAM    3
`define QBR_CTRL_ANEG     4
`define QBR_CTRL_FEF      5
`define QBR_CTRL_TBT      6
`define QBR_CTRL_RST      7'h5d
`define QBR_FIBER_RST     4'h0
`define QBR_DUPLEX_RST    4'h0
`define QBR_STRAP_WAIT    2'h3
`define QBR_REF_WIN       5'h1f
`define QBR_SLOW_HALF     3
`endif

// ==== qbr_pkg.sv ====
// Types shared by the bused port router
package qbr_pkg;
  typedef logic [3:0] qbr_chan_t;
  typedef logic [3:0] qbr_nib_t;
  typedef enum logic [1:0] {
    QBR_WAIT = 2'b01,
    QBR_RUN  = 2'b10
  } qbr_cap_t;
endpackage : qbr_pkg

// ==== qbr_router.sv ====
// Bused port router of a four-channel 10/100 transceiver
//
// Overview of operation
// - Separate submode: per-port carrier, collision, selects per speed, four each
// - Slow clocks and serial data of all channels share port B
// - Fast clocks, nibbles, errors and valid of all channels share port A
// - Smart submode: one common carrier, select and collision set per channel
// - Smart submode: slow transmit select positions become security inputs
// - Port A is a 100 Mbit/s nibble port, port B a 10 Mbit/s serial port
// - Channel speed and port attachment follow autonegotiation by themselves
// - Each channel's data is steered to the port matching its speed
// - Fast transceivers use the 25 MHz clock, slow ones the 20 MHz clock
// - Detect whether the 25 MHz reference is an external clock or crystal
// - 20 MHz clock internal unless select strap high after reset
// - Fiber mode per channel by strap pin or register bit
// - Fiber duplex per channel by register or all by strap
// - Fiber channel enables its signal detect input
// - Fiber forces far-end fault, drops MLT-3, scrambling, negotiation, 10Base-T
`timescale 1ns/1ns
`include "qbr_defines.svh"
module qbr_router #(
  parameter int SLOW_HALF = `QBR_SLOW_HALF
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic [31:0]          prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire qbr_pkg::qbr_chan_t an_resolved,
  input  wire qbr_pkg::qbr_chan_t an_fast,
  input  wire logic            ext_ref25_clk,
  input  wire logic            ext_ref20_select,
  input  wire logic            all_ports_duplex_strap,
  input  wire qbr_pkg::qbr_chan_t fiber_enable_strap,
  output logic                 ref25_external,
  output logic                 ref20_external,
  output qbr_pkg::qbr_chan_t   fast_clock_use,
  output qbr_pkg::qbr_chan_t   slow_clock_use,
  output qbr_pkg::qbr_chan_t   far_end_fault_en,
  output qbr_pkg::qbr_chan_t   mlt3_en,
  output qbr_pkg::qbr_chan_t   scramble_en,
  output qbr_pkg::qbr_chan_t   aneg_en,
  output qbr_pkg::qbr_chan_t   tenbase_en,
  output qbr_pkg::qbr_chan_t   signal_detect_en,
  output qbr_pkg::qbr_chan_t   full_duplex,
  input  wire logic            link_clk,
  input  wire logic            link_rstn,
  input  wire qbr_pkg::qbr_chan_t fiber_signal_detect,
  input  wire logic [15:0]     ch_rxd,
  input  wire qbr_pkg::qbr_chan_t ch_rx_dv,
  input  wire qbr_pkg::qbr_chan_t ch_rx_er,
  input  wire qbr_pkg::qbr_chan_t ch_rxd_serial,
  input  wire qbr_pkg::qbr_chan_t ch_carrier,
  input  wire qbr_pkg::qbr_chan_t ch_collision,
  output qbr_pkg::qbr_nib_t    ch_txd,
  output logic                 ch_tx_er,
  output qbr_pkg::qbr_chan_t   ch_tx_en_fast,
  output logic                 ch_txd_serial,
  output qbr_pkg::qbr_chan_t   ch_tx_en_slow,
  input  wire qbr_pkg::qbr_chan_t fast_receive_select,
  input  wire qbr_pkg::qbr_chan_t slow_receive_select,
  input  wire qbr_pkg::qbr_chan_t fast_transmit_select,
  input  wire qbr_pkg::qbr_chan_t slow_transmit_select,
  input  wire qbr_pkg::qbr_nib_t  fast_port_txd,
  input  wire logic            fast_port_tx_er,
  input  wire logic            slow_port_txd,
  output qbr_pkg::qbr_chan_t   fast_carrier_sense,
  output qbr_pkg::qbr_chan_t   slow_carrier_sense,
  output qbr_pkg::qbr_chan_t   fast_collision,
  output qbr_pkg::qbr_chan_t   slow_collision,
  output qbr_pkg::qbr_nib_t    fast_port_rxd,
  output logic                 fast_port_rx_dv,
  output logic                 fast_port_rx_er,
  output logic                 fast_port_oe,
  output logic                 slow_port_rxd,
  output logic                 slow_port_oe,
  output logic                 fast_port_rx_clock,
  output logic                 fast_port_tx_clock,
  output logic                 slow_port_rx_clock,
  output logic                 slow_port_tx_clock
);
  import qbr_pkg::*;

  // Lowest selected channel index, for the shared port mux
  function automatic logic [1:0] qbr_pick(input qbr_chan_t s);
    return s[0] ? 2'h0 : s[1] ? 2'h1 : s[2] ? 2'h2 : 2'h3;
  endfunction : qbr_pick

  // APB-side state
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [6:0]  ctrl;
    qbr_chan_t   fiber;
    qbr_chan_t   duplex;
    logic [6:0]  strap_s1;
    logic [6:0]  strap_s2;
    qbr_cap_t    cap;
    logic [1:0]  cap_cnt;
    logic        ref20;
    logic        dup_strap;
    qbr_chan_t   fib_strap;
    logic [2:0]  ref_sh;
    logic [4:0]  ref_cnt;
    logic        ref_seen;
    logic        ref_ext;
    qbr_chan_t   att_f;
    qbr_chan_t   att_s;
    qbr_chan_t   fib_eff;
    qbr_chan_t   fef;
    qbr_chan_t   mlt3;
    qbr_chan_t   scram;
    qbr_chan_t   aneg;
    qbr_chan_t   tbt;
    qbr_chan_t   fdx;
  } qbr_preg_t;

  qbr_preg_t p_q, p_d;
  logic      ap_acc;
  logic      ap_hit;

  // Bus decode and configuration logic
  always_comb begin
    p_d = p_q;
    ap_acc = psel & penable & p_q.pready;
    ap_hit = (paddr == `QBR_OFF_CTRL) || (paddr == `QBR_OFF_FIBER)
          || (paddr == `QBR_OFF_DUPLEX) || (paddr == `QBR_OFF_STATUS);
    p_d.pready = psel & ~penable;
    if (psel & ~penable) begin
      p_d.pslverr = ~ap_hit;
      unique case (paddr)
        `QBR_OFF_CTRL:   p_d.prdata = {25'h0, p_q.ctrl};
        `QBR_OFF_FIBER:  p_d.prdata = {28'h0, p_q.fiber};
        `QBR_OFF_DUPLEX: p_d.prdata = {28'h0, p_q.duplex};
        `QBR_OFF_STATUS: p_d.prdata = {17'h0, p_q.dup_strap,
                           p_q.ref20, p_q.ref_ext, p_q.att_s,
                           p_q.fib_eff, p_q.att_f};
        default:         p_d.prdata = 32'h0;
      endcase
    end
    // Writes land only at the accepted access edge
    if (ap_acc & pwrite) begin
      unique case (paddr)
        `QBR_OFF_CTRL:   p_d.ctrl   = pwdata[6:0];
        `QBR_OFF_FIBER:  p_d.fiber  = pwdata[3:0];
        `QBR_OFF_DUPLEX: p_d.duplex = pwdata[3:0];
        default:         ;
      endcase
    end
    // Strap pins pass two flops, then are caught once
    p_d.strap_s1 = {ext_ref25_clk, ext_ref20_select,
                    all_ports_duplex_strap, fiber_enable_strap};
    p_d.strap_s2 = p_q.strap_s1;
    unique case (p_q.cap)
      QBR_WAIT: begin
        p_d.cap_cnt = p_q.cap_cnt + 2'h1;
        if (p_q.cap_cnt == `QBR_STRAP_WAIT) begin
          p_d.ref20     = p_q.strap_s2[5];
          p_d.dup_strap = p_q.strap_s2[4];
          p_d.fib_strap = p_q.strap_s2[3:0];
          p_d.cap       = QBR_RUN;
        end
      end
      QBR_RUN: ;
    endcase
    // Edges on the 25 MHz input within a window mean an external clock
    p_d.ref_sh = {p_q.ref_sh[1:0], p_q.strap_s2[6]};
    p_d.ref_cnt = p_q.ref_cnt + 5'h1;
    if (p_q.ref_cnt == `QBR_REF_WIN) begin
      p_d.ref_ext  = p_q.ref_seen;
      p_d.ref_seen = 1'b0;
    end
    p_d.ref_seen = p_d.ref_seen | (p_q.ref_sh[2] ^ p_q.ref_sh[1]); // Set wins
    // Fiber, speed and forced per-channel settings
    p_d.fib_eff = p_q.fiber | p_q.fib_strap;
    p_d.att_f = an_resolved & (an_fast | p_d.fib_eff);
    p_d.att_s = an_resolved & ~an_fast & ~p_d.fib_eff;
    for (int i = 0; i < 4; i++) begin
      p_d.fef[i]   = p_d.fib_eff[i] | p_q.ctrl[`QBR_CTRL_FEF];
      p_d.mlt3[i]  = ~p_d.fib_eff[i] & p_q.ctrl[`QBR_CTRL_MLT3];
      p_d.scram[i] = ~p_d.fib_eff[i] & p_q.ctrl[`QBR_CTRL_SCRAM];
      p_d.aneg[i]  = ~p_d.fib_eff[i] & p_q.ctrl[`QBR_CTRL_ANEG];
      p_d.tbt[i]   = ~p_d.fib_eff[i] & p_q.ctrl[`QBR_CTRL_TBT];
      p_d.fdx[i]   = p_q.duplex[i] | p_q.dup_strap;
    end
  end

  // APB-side registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_q <= '{cap: QBR_WAIT, ctrl: `QBR_CTRL_RST,
               fiber: `QBR_FIBER_RST, duplex: `QBR_DUPLEX_RST,
               default: '0};
    end else begin
      p_q <= p_d;
    end
  end

  assign prdata           = p_q.prdata;
  assign pready           = p_q.pready;
  assign pslverr          = p_q.pslverr;
  assign ref25_external   = p_q.ref_ext;
  assign ref20_external   = p_q.ref20;
  assign fast_clock_use   = p_q.att_f;
  assign slow_clock_use   = p_q.att_s;
  assign far_end_fault_en = p_q.fef;
  assign mlt3_en          = p_q.mlt3;
  assign scramble_en      = p_q.scram;
  assign aneg_en          = p_q.aneg;
  assign tenbase_en       = p_q.tbt;
  assign signal_detect_en = p_q.fib_eff;
  assign full_duplex      = p_q.fdx;

  // Link-side state
  typedef struct packed {
    logic [13:0] cfg_s1;
    logic [13:0] cfg_s2;
    logic [25:0] pin_s1;
    logic [25:0] pin_s2;
    qbr_nib_t    txd;
    logic        tx_er;
    qbr_chan_t   txen_f;
    logic        txd_s;
    qbr_chan_t   txen_s;
    qbr_chan_t   crs_f;
    qbr_chan_t   crs_s;
    qbr_chan_t   col_f;
    qbr_chan_t   col_s;
    qbr_nib_t    rxd;
    logic        rx_dv;
    logic        rx_er;
    logic        f_oe;
    logic        rxd_s;
    logic        s_oe;
    logic        fclk;
    logic        sclk;
    logic [2:0]  sdiv;
  } qbr_lreg_t;

  qbr_lreg_t l_q, l_d;
  qbr_chan_t att_f, att_s, fib, sd, crs_v, rsel_f, rsel_s;
  qbr_chan_t tsel_f, tsel_s, secure, sel_fr, sel_sr, sel_ft, sel_st;
  logic      smart, bused;
  logic [1:0] fi, si;

  // Port routing and bus ownership
  always_comb begin
    l_d = l_q;
    l_d.cfg_s1 = {p_q.ctrl[`QBR_CTRL_BUSED], p_q.ctrl[`QBR_CTRL_SMART],
                  p_q.fib_eff, p_q.att_s, p_q.att_f};
    l_d.cfg_s2 = l_q.cfg_s1;
    l_d.pin_s1 = {fiber_signal_detect, slow_port_txd, fast_port_tx_er,
                  fast_port_txd, slow_transmit_select,
                  fast_transmit_select, slow_receive_select,
                  fast_receive_select};
    l_d.pin_s2 = l_q.pin_s1;
    att_f  = l_q.cfg_s2[3:0];
    att_s  = l_q.cfg_s2[7:4];
    fib    = l_q.cfg_s2[11:8];
    smart  = l_q.cfg_s2[12];
    bused  = l_q.cfg_s2[13];
    rsel_f = l_q.pin_s2[3:0];
    rsel_s = l_q.pin_s2[7:4];
    tsel_f = l_q.pin_s2[11:8];
    tsel_s = l_q.pin_s2[15:12];
    sd     = l_q.pin_s2[25:22];
    crs_v  = ch_carrier & (~fib | sd);
    // Smart mode reuses the fast pins as the common set
    secure = smart ? tsel_s : 4'h0;
    sel_fr = {4{bused}} & att_f & rsel_f;
    sel_sr = {4{bused}} & att_s & (smart ? rsel_f : rsel_s);
    sel_ft = {4{bused}} & att_f & tsel_f & ~secure;
    sel_st = {4{bused}} & att_s & (smart ? tsel_f : tsel_s) & ~secure;
    fi = qbr_pick(sel_fr);
    si = qbr_pick(sel_sr);
    // Carrier and collision status per speed or common
    l_d.crs_f = {4{bused}} & (att_f | {4{smart}} & att_s) & crs_v;
    l_d.col_f = {4{bused}} & (att_f | {4{smart}} & att_s) & ch_collision;
    l_d.crs_s = {4{bused & ~smart}} & att_s & crs_v;
    l_d.col_s = {4{bused & ~smart}} & att_s & ch_collision;
    // Port A: one selected fast channel drives the nibble port
    l_d.f_oe  = |sel_fr;
    l_d.rxd   = l_d.f_oe ? ch_rxd[4*fi +: 4] : 4'h0;
    l_d.rx_dv = l_d.f_oe & ch_rx_dv[fi];
    l_d.rx_er = l_d.f_oe & ch_rx_er[fi];
    // Port B: one selected slow channel drives the serial line
    l_d.s_oe  = |sel_sr;
    l_d.rxd_s = l_d.s_oe & ch_rxd_serial[si];
    // Transmit data broadcast, enable only to the selected channel
    l_d.txd    = l_q.pin_s2[19:16];
    l_d.tx_er  = l_q.pin_s2[20];
    l_d.txen_f = sel_ft;
    l_d.txd_s  = l_q.pin_s2[21];
    l_d.txen_s = sel_st;
    // Port clocks: fast toggles each edge, slow from a divider
    l_d.fclk = ~l_q.fclk;
    if (l_q.sdiv == 3'(SLOW_HALF - 1)) begin
      l_d.sdiv = 3'h0;
      l_d.sclk = ~l_q.sclk;
    end else begin
      l_d.sdiv = l_q.sdiv + 3'h1;
    end
  end

  // Link-side registers
  always_ff @(posedge link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  assign ch_txd             = l_q.txd;
  assign ch_tx_er           = l_q.tx_er;
  assign ch_tx_en_fast      = l_q.txen_f;
  assign ch_txd_serial      = l_q.txd_s;
  assign ch_tx_en_slow      = l_q.txen_s;
  assign fast_carrier_sense = l_q.crs_f;
  assign slow_carrier_sense = l_q.crs_s;
  assign fast_collision     = l_q.col_f;
  assign slow_collision     = l_q.col_s;
  assign fast_port_rxd      = l_q.rxd;
  assign fast_port_rx_dv    = l_q.rx_dv;
  assign fast_port_rx_er    = l_q.rx_er;
  assign fast_port_oe       = l_q.f_oe;
  assign slow_port_rxd      = l_q.rxd_s;
  assign slow_port_oe       = l_q.s_oe;
  assign fast_port_rx_clock = l_q.fclk;
  assign fast_port_tx_clock = l_q.fclk;
  assign slow_port_rx_clock = l_q.sclk;
  assign slow_port_tx_clock = l_q.sclk;

  // Checks on the link side
  a_smart_slow_quiet: assert property (
    @(posedge link_clk) disable iff (!link_rstn)
    smart |=> (slow_carrier_sense == 4'h0) && (slow_collision == 4'h0))
    else $error("slow status active in smart mode");
  a_fast_port_owner: assert property (
    @(posedge link_clk) disable iff (!link_rstn)
    (sel_fr == 4'h0) |=> !fast_port_oe && fast_port_rxd == 4'h0)
    else $error("fast port driven with no channel selected");
  a_slow_port_owner: assert property (
    @(posedge link_clk) disable iff (!link_rstn)
    (sel_sr == 4'h0) |=> !slow_port_oe && !slow_port_rxd)
    else $error("slow port driven with no channel selected");
  a_fast_rx_route: assert property (
    @(posedge link_clk) disable iff (!link_rstn)
    (sel_fr[1] && !sel_fr[0]) |=> fast_port_rxd == $past(ch_rxd[7:4]))
    else $error("fast port data not from lowest selected channel");
  a_security_block: assert property (
    @(posedge link_clk) disable iff (!link_rstn)
    (smart && secure[0]) |=> !ch_tx_en_fast[0] && !ch_tx_en_slow[0])
    else $error("secured channel got transmit enable");
  a_fiber_no_slow: assert property (
    @(posedge link_clk) disable iff (!link_rstn)
    fib[1] |=> !ch_tx_en_slow[1] && !slow_carrier_sense[1])
    else $error("fiber channel routed to slow port");
  // Checks on the register side
  a_fiber_forces: assert property (
    @(posedge pclk) disable iff (!presetn)
    p_q.fib_eff[2] |-> far_end_fault_en[2] && !mlt3_en[2]
      && !scramble_en[2] && !aneg_en[2] && !tenbase_en[2])
    else $error("fiber channel not forced");
  a_strap_once: assert property (
    @(posedge pclk) disable iff (!presetn)
    (p_q.cap == QBR_RUN) |=> $stable(ref20_external))
    else $error("clock select strap changed after capture");
  a_apb_answer: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready ##1 !pready)
    else $error("bus answer not one cycle after setup");
  a_speed_attach: assert property (
    @(posedge pclk) disable iff (!presetn)
    (an_resolved[3] && !an_fast[3] && !p_d.fib_eff[3])
      |=> slow_clock_use[3] && !fast_clock_use[3])
    else $error("slow channel not attached to slow port");
  c_fast_owner: cover property (
    @(posedge link_clk) disable iff (!link_rstn) fast_port_oe);
  c_slow_owner: cover property (
    @(posedge link_clk) disable iff (!link_rstn) slow_port_oe);
  c_smart_mode: cover property (
    @(posedge link_clk) disable iff (!link_rstn) smart && |sel_sr);
  c_fiber_on: cover property (
    @(posedge pclk) disable iff (!presetn) |signal_detect_en);

endmodule : qbr_router

// ==== qbr_rep_model.sv ====
// Behavioural repeater standing on the far side of the bused ports
`timescale 1ns/1ns
module qbr_rep_model (
  input  wire logic               link_clk,
  input  wire logic [1:0]         lag,
  input  wire qbr_pkg::qbr_chan_t want_frx,
  input  wire qbr_pkg::qbr_chan_t want_srx,
  input  wire qbr_pkg::qbr_chan_t want_ftx,
  input  wire qbr_pkg::qbr_chan_t want_stx,
  input  wire qbr_pkg::qbr_nib_t  want_txd,
  input  wire logic               want_txer,
  input  wire logic               want_stxd,
  output qbr_pkg::qbr_chan_t      fast_receive_select,
  output qbr_pkg::qbr_chan_t      slow_receive_select,
  output qbr_pkg::qbr_chan_t      fast_transmit_select,
  output qbr_pkg::qbr_chan_t      slow_transmit_select,
  output qbr_pkg::qbr_nib_t       fast_port_txd,
  output logic                    fast_port_tx_er,
  output logic                    slow_port_txd
);
  import qbr_pkg::*;
  logic [21:0] pipe_q [4] = '{default: 22'h0};
  logic [21:0] now_w;
  logic [3:0]  tog_q = 4'h0;

  // Request pipeline, lag picks a prompt or a slow answer
  always_ff @(posedge link_clk) begin
    pipe_q[0] <= {want_frx, want_srx, want_ftx, want_stx, want_txd,
                  want_txer, want_stxd};
    for (int k = 1; k < 4; k++) begin
      pipe_q[k] <= pipe_q[k-1];
    end
    tog_q <= tog_q + 4'h1;
  end
  assign now_w = pipe_q[lag];

  // Selects name the channel served; idle data lines keep changing
  always_ff @(posedge link_clk) begin
    fast_receive_select  <= now_w[21:18];
    slow_receive_select  <= now_w[17:14];
    fast_transmit_select <= now_w[13:10];
    slow_transmit_select <= now_w[9:6];
    fast_port_txd        <= (|now_w[13:10]) ? now_w[5:2] : tog_q;
    fast_port_tx_er      <= (|now_w[13:10]) ? now_w[1] : tog_q[0];
    slow_port_txd        <= (|now_w[9:6]) ? now_w[0] : tog_q[1];
  end
endmodule : qbr_rep_model

// ==== tb_top.sv ====
// Self-checking bench of the bused port router
`timescale 1ns/1ns
`include "qbr_defines.svh"
module tb_top;
  import qbr_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, r_v;
  logic        pready, pslverr, e_v, b_v;
  qbr_chan_t   an_resolved = 4'hf, an_fast = 4'h1;
  qbr_chan_t   fiber_enable_strap = 4'h4;
  logic        ext_ref25_clk = 0, ext_ref20_select = 1;
  logic        all_ports_duplex_strap = 0, ref25_external, ref20_external;
  qbr_chan_t   fast_clock_use, slow_clock_use, far_end_fault_en, mlt3_en;
  qbr_chan_t   scramble_en, aneg_en, tenbase_en, signal_detect_en;
  qbr_chan_t   full_duplex, ch_tx_en_fast, ch_tx_en_slow;
  logic        link_clk = 0, link_rstn = 0;
  qbr_chan_t   fiber_signal_detect = 0, ch_carrier = 0, ch_collision = 0;
  qbr_chan_t   ch_rx_dv = 4'h5, ch_rx_er = 4'h2, ch_rxd_serial = 4'h9;
  logic [15:0] ch_rxd = 16'h4c2a;
  qbr_nib_t    ch_txd, fast_port_txd, fast_port_rxd;
  logic        ch_tx_er, ch_txd_serial, fast_port_tx_er, slow_port_txd;
  qbr_chan_t   fast_receive_select, slow_receive_select;
  qbr_chan_t   fast_transmit_select, slow_transmit_select;
  qbr_chan_t   fast_carrier_sense, slow_carrier_sense;
  qbr_chan_t   fast_collision, slow_collision;
  logic        fast_port_rx_dv, fast_port_rx_er, fast_port_oe;
  logic        slow_port_rxd, slow_port_oe, fast_port_rx_clock;
  logic        fast_port_tx_clock, slow_port_rx_clock, slow_port_tx_clock;
  logic [1:0]  lag = 0;
  qbr_chan_t   want_frx = 0, want_srx = 0, want_ftx = 0, want_stx = 0;
  qbr_nib_t    want_txd = 4'h6;
  logic        want_txer = 1, want_stxd = 1;
  int          error_cnt = 0, n_tests = 0;

  qbr_router #(.SLOW_HALF(3)) DUT (.*);
  qbr_rep_model REP (.*);

  // Clocks: APB, link and the external 25 MHz reference
  always #10 pclk = ~pclk;
  always #32 link_clk = ~link_clk;
  always #20 ext_ref25_clk = ~ext_ref25_clk;

  task end_sim;
    if (error_cnt == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  // One APB transfer, held until pready is seen
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1;
    penable <= 0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) error_cnt++;
    r_v = prdata;
    e_v = pslverr;
    psel    <= 0;
    penable <= 0;
  endtask : xfer

  task rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    xfer(0, a, 32'h0);
    cmp("prdata", e, r_v);
    cmp("pslverr", ee, e_v);
  endtask : rd_chk

  task lw;
    repeat (10) @(posedge link_clk);
    #1;
  endtask : lw

  task req(input qbr_chan_t a, input qbr_chan_t b, input qbr_chan_t c,
           input qbr_chan_t d);
    @(posedge link_clk);
    want_frx <= a;
    want_srx <= b;
    want_ftx <= c;
    want_stx <= d;
    lw();
  endtask : req

  // Watchdog against a hang
  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn   <= 1;
    link_rstn <= 1;
    repeat (50) @(posedge pclk);
    rd_chk(`QBR_OFF_CTRL, 32'h5d, 0);
    rd_chk(`QBR_OFF_FIBER, 32'h0, 0);
    rd_chk(`QBR_OFF_DUPLEX, 32'h0, 0);
    rd_chk(8'h10, 32'h0, 1);
    rd_chk(`QBR_OFF_STATUS, 32'h3a45, 0);
    cmp("ref25_external", 1, ref25_external);
    cmp("ref20_external", 1, ref20_external);
    xfer(1, `QBR_OFF_FIBER, 32'h2);
    xfer(1, `QBR_OFF_DUPLEX, 32'h1);
    xfer(1, `QBR_OFF_STATUS, 32'h0);
    repeat (4) @(posedge pclk);
    #1;
    cmp("far_end_fault_en", 4'h6, far_end_fault_en);
    cmp("mlt3_en", 4'h9, mlt3_en);
    cmp("scramble_en", 4'h9, scramble_en);
    cmp("aneg_en", 4'h9, aneg_en);
    cmp("tenbase_en", 4'h9, tenbase_en);
    cmp("signal_detect_en", 4'h6, signal_detect_en);
    cmp("full_duplex", 4'h1, full_duplex);
    cmp("fast_clock_use", 4'h7, fast_clock_use);
    cmp("slow_clock_use", 4'h8, slow_clock_use);
    rd_chk(`QBR_OFF_STATUS, 32'h3867, 0);
    // Receive routing on both ports
    req(4'h1, 4'h0, 4'h0, 4'h0);
    cmp("fast_port_oe", 1, fast_port_oe);
    cmp("fast_port_rxd", 4'ha, fast_port_rxd);
    cmp("fast_port_rx_dv", 1, fast_port_rx_dv);
    cmp("fast_port_rx_er", 0, fast_port_rx_er);
    @(posedge link_clk) b_v = fast_port_rx_clock;
    @(posedge link_clk);
    cmp("fast_port_rx_clock", !b_v, fast_port_rx_clock);
    cmp("fast_port_tx_clock", !b_v, fast_port_tx_clock);
    b_v = slow_port_rx_clock;
    repeat (`QBR_SLOW_HALF) @(posedge link_clk);
    cmp("slow_port_rx_clock", !b_v, slow_port_rx_clock);
    cmp("slow_port_tx_clock", !b_v, slow_port_tx_clock);
    ch_rxd        <= 16'h4c3a;
    ch_rx_dv      <= 4'h2;
    ch_rx_er      <= 4'h0;
    ch_rxd_serial <= 4'h1;
    req(4'h6, 4'h9, 4'h0, 4'h0);
    cmp("fast_port_rxd", 4'h3, fast_port_rxd);
    cmp("fast_port_rx_dv", 1, fast_port_rx_dv);
    cmp("slow_port_oe", 1, slow_port_oe);
    cmp("slow_port_rxd", 0, slow_port_rxd);
    req(4'h8, 4'h1, 4'h0, 4'h0);
    cmp("fast_port_oe", 0, fast_port_oe);
    cmp("slow_port_oe", 0, slow_port_oe);
    // Transmit selection with a slow repeater answer
    lag <= 2'h3;
    req(4'h0, 4'h0, 4'h2, 4'h8);
    cmp("ch_tx_en_fast", 4'h2, ch_tx_en_fast);
    cmp("ch_txd", 4'h6, ch_txd);
    cmp("ch_tx_er", 1, ch_tx_er);
    cmp("ch_tx_en_slow", 4'h8, ch_tx_en_slow);
    cmp("ch_txd_serial", 1, ch_txd_serial);
    // Separate carrier and collision sets
    ch_carrier   <= 4'hf;
    ch_collision <= 4'hf;
    lw();
    cmp("fast_carrier_sense", 4'h1, fast_carrier_sense);
    cmp("slow_carrier_sense", 4'h8, slow_carrier_sense);
    cmp("fast_collision", 4'h7, fast_collision);
    cmp("slow_collision", 4'h8, slow_collision);
    fiber_signal_detect <= 4'hf;
    lw();
    cmp("fast_carrier_sense", 4'h7, fast_carrier_sense);
    // Smart submode with security blocking
    xfer(1, `QBR_OFF_CTRL, 32'h5f);
    lag <= 2'h0;
    req(4'h8, 4'h0, 4'h3, 4'h1);
    cmp("slow_port_oe", 1, slow_port_oe);
    cmp("fast_port_oe", 0, fast_port_oe);
    cmp("ch_tx_en_fast", 4'h2, ch_tx_en_fast);
    cmp("fast_carrier_sense", 4'hf, fast_carrier_sense);
    cmp("slow_carrier_sense", 4'h0, slow_carrier_sense);
    // Bused mode off silences the ports
    xfer(1, `QBR_OFF_CTRL, 32'h5c);
    req(4'h1, 4'h8, 4'h1, 4'h0);
    cmp("fast_port_oe", 0, fast_port_oe);
    cmp("slow_port_oe", 0, slow_port_oe);
    cmp("ch_tx_en_fast", 4'h0, ch_tx_en_fast);
    end_sim();
  end
endmodule : tb_top
